// ==== bench/dtb_cpu_model.sv ====
// Bus master model of the CPU that reads the debug registers.
module dtb_cpu_model (
    // Clock.
    input wire logic ref_clk_i,
    // Avalon-MM master.
    output logic [7:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [3:0] byteenable_o,
    output logic [31:0] writedata_o,
    input wire logic [31:0] readdata_i,
    input wire logic waitrequest_i
);
    timeunit 1ns;
    timeprecision 1ns;
    int timeouts = 0;

    // Idle bus at time zero.
    initial begin
        address_o = 8'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        byteenable_o = 4'h0;
        writedata_o = 32'h0;
    end

    // One transfer, held until waitrequest is seen low or 64 cycles pass; then address and write data show inverted values.
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                        output logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        address_o <= a;
        read_o <= rd;
        write_o <= ~rd;
        byteenable_o <= be;
        writedata_o <= wd;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 64);
        if (waitrequest_i !== 1'b0) timeouts++;
        d = readdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
        address_o <= ~a;
        writedata_o <= ~wd;
    endtask
endmodule

// ==== bench/dtb_readout_properties.sv ====
// Concurrent checks on the ports of the trace buffer readout block.
// ==========================================================
// Checker module.
module dtb_readout_properties
    import dtb_pkg::*;
(
    // Clock and resets.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic sys_rst_i,
    // Register bus.
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    // Trace side.
    input wire logic secure_i,
    input wire logic trace_store_i,
    input wire logic armed_o,
    input wire logic trace_source_bit_o,
    input wire logic trigger_align_bit_o,
    input wire logic tracing_en_o,
    input wire logic buffer_full_flag_o,
    input wire logic [DTB_PTR_W-1:0] line_count_field_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Completed bus cycles and top-line stores of interest.
    logic arm_done;
    logic rd_done;
    logic store_top;
    assign arm_done = write_i & ~waitrequest_o & (address_i == {DTB_IDX_CONTROL, 2'b00}) & byteenable_i[0]
        & writedata_i[DTB_CTL_ARM];
    assign rd_done = read_i & ~waitrequest_o;
    assign store_top = trace_store_i & tracing_en_o & ~buffer_full_flag_o & (line_count_field_o == 6'h3F)
        & ~arm_done & ~sys_rst_i;

    // ==========================================================
    // Properties.
    property p_win_zero;
        rd_done && address_i == {DTB_IDX_WINDOW, 2'b00} && (armed_o || !trace_source_bit_o || byteenable_i != DTB_WORD_BE) |-> readdata_o == 32'h0;
    endproperty
    a_win_zero: assert property (p_win_zero) else $error("window read not zero");
    property p_count_read;
        rd_done && address_i == {DTB_IDX_COUNT, 2'b00} |-> readdata_o[7:0] == {buffer_full_flag_o, 1'b0, line_count_field_o};
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong");
    property p_count_step;
        line_count_field_o != $past(line_count_field_o) |-> line_count_field_o == 6'($past(line_count_field_o) + 6'h01) || $past(arm_done);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count moved wrongly");
    property p_arm_clear;
        arm_done |=> !buffer_full_flag_o && line_count_field_o == 6'h00;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arming did not clear");
    property p_sysrst_keep;
        sys_rst_i && !trace_store_i && !arm_done |=> $stable(line_count_field_o) && $stable(buffer_full_flag_o);
    endproperty
    a_sysrst_keep: assert property (p_sysrst_keep) else $error("system reset changed count");
    property p_begin_stop;
        store_top && trigger_align_bit_o |=> !armed_o && buffer_full_flag_o && line_count_field_o == 6'h00;
    endproperty
    a_begin_stop: assert property (p_begin_stop) else $error("begin mode did not stop");
    property p_end_wrap;
        store_top && !trigger_align_bit_o |=> armed_o && buffer_full_flag_o && line_count_field_o == 6'h00;
    endproperty
    a_end_wrap: assert property (p_end_wrap) else $error("end mode wrap wrong");
    property p_secure;
        secure_i [*4] |-> !tracing_en_o;
    endproperty
    a_secure: assert property (p_secure) else $error("tracing while secured");
endmodule

bind dtb_readout dtb_readout_properties u_props (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sys_rst_i(sys_rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .secure_i(secure_i), .trace_store_i(trace_store_i), .armed_o(armed_o),
    .trace_source_bit_o(trace_source_bit_o), .trigger_align_bit_o(trigger_align_bit_o),
    .tracing_en_o(tracing_en_o), .buffer_full_flag_o(buffer_full_flag_o), .line_count_field_o(line_count_field_o)
);

// ==== bench/tb_top.sv ====
// Self-checking testbench of the trace buffer readout block.
module tb_top
    import dtb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] a_ctl = {DTB_IDX_CONTROL, 2'b00};
    localparam logic [7:0] a_sts = {DTB_IDX_STATUS, 2'b00};
    localparam logic [7:0] a_win = {DTB_IDX_WINDOW, 2'b00};
    localparam logic [7:0] a_cnt = {DTB_IDX_COUNT, 2'b00};
    localparam logic [7:0] a_sel = {DTB_IDX_SELECT, 2'b00};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sys_rst = 1'b0;
    logic secure = 1'b0;
    logic store = 1'b0;
    logic [19:0] tdata = 20'h00000;
    logic [7:0] address;
    logic read, write, wait_req, armed, tsrc, trigger_align_bit, full;
    logic [3:0] be, sc1, sc2, sc3;
    logic [31:0] wdata, rdata;
    logic [5:0] cnt;
    int fail_count = 0;
    int checks_done = 0;

    // ==========================================================
    // Clock, design and bus master.
    always #5 clk = ~clk;
    dtb_readout DUT (
        .ref_clk_i(clk), .rst_n_i(rst_n), .sys_rst_i(sys_rst), .address_i(address), .read_i(read),
        .write_i(write), .byteenable_i(be), .writedata_i(wdata), .readdata_o(rdata), .waitrequest_o(wait_req),
        .secure_i(secure), .trace_store_i(store), .trace_data_i(tdata), .session_end_i(1'b0),
        .seq_state_i(3'h3), .match_flags_i(3'h5), .armed_o(armed), .trace_source_bit_o(tsrc),
        .trigger_align_bit_o(trigger_align_bit), .tracing_en_o(), .state_one_control_o(sc1), .state_two_control_o(sc2),
        .state_three_control_o(sc3), .buffer_full_flag_o(full), .line_count_field_o(cnt)
    );
    dtb_cpu_model cpu (
        .ref_clk_i(clk), .address_o(address), .read_o(read), .write_o(write), .byteenable_o(be),
        .writedata_o(wdata), .readdata_i(rdata), .waitrequest_i(wait_req)
    );

    // ==========================================================
    // Helpers: line pattern, compare, bus access, line capture.
    function automatic logic [31:0] ln(input int i, input bit h);
        logic [19:0] v;
        v = {~i[3:0], 10'h000, i[5:0]};
        return h ? {28'h0, v[19:16]} : {16'h0, v[15:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH time %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic bus(input logic rd, input logic [7:0] a, input logic [3:0] b, input logic [31:0] wd,
                       output logic [31:0] d);
        cpu.xfer(rd, a, b, wd, d);
        if (cpu.timeouts != 0) begin
            fail_count++;
            print_verdict();
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b1, a, b, 32'h0, d);
        chk(d & m, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] b);
        logic [31:0] d;
        bus(1'b0, a, b, wd, d);
    endtask
    task automatic put(input int n);
        for (int i = 0; i < n; i++) begin
            tdata <= 20'(ln(i, 1'b1) << 16 | ln(i, 1'b0));
            store <= 1'b1;
            @(posedge clk);
        end
        store <= 1'b0;
        @(posedge clk);
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        rc(a_cnt, 4'hF, 32'hFF, 32'h0);
        rc(a_sts, 4'hF, 32'h87, 32'h03);
        wr(a_cnt, 32'hFF, 4'hF);
        rc(a_cnt, 4'hF, 32'hFF, 32'h0);
        rc(8'hFC, 4'hF, 32'hFFFFFFFF, 32'h0);
        $display("test reset_values done");
    endtask
    task automatic t_readout();
        wr(a_ctl, 32'hC0, 4'h1);
        put(3);
        rc(a_cnt, 4'hF, 32'hFF, 32'h03);
        rc(a_win, 4'h3, 32'hFFFF, 32'h0);
        wr(a_ctl, 32'h40, 4'h1);
        rc(a_win, 4'h3, 32'hFFFF, 32'h0);
        wr(a_win, 32'h0, 4'h3);
        rc(a_win, 4'h1, 32'hFFFF, 32'h0);
        rc(a_win, 4'h3, 32'hFFFF, ln(0, 1'b0));
        rc(a_win, 4'h3, 32'hF, ln(0, 1'b1));
        wr(a_ctl, 32'h00, 4'h1);
        rc(a_win, 4'h3, 32'hFFFF, 32'h0);
        wr(a_ctl, 32'h40, 4'h1);
        rc(a_win, 4'h3, 32'hFFFF, ln(1, 1'b0));
        rc(a_cnt, 4'hF, 32'hFF, 32'h03);
        $display("test readout done");
    endtask
    task automatic t_wrap();
        wr(a_ctl, 32'hC0, 4'h1);
        put(66);
        chk({31'h0, armed}, 32'h1);
        rc(a_cnt, 4'hF, 32'hFF, 32'h82);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rc(a_cnt, 4'hF, 32'hFF, 32'h82);
        wr(a_ctl, 32'h40, 4'h1);
        wr(a_win, 32'h0, 4'h3);
        rc(a_win, 4'h3, 32'hFFFF, ln(2, 1'b0));
        wr(a_ctl, 32'hC0, 4'h1);
        rc(a_cnt, 4'hF, 32'hFF, 32'h0);
        rc(a_sts, 4'hF, 32'h80, 32'h0);
        wr(a_ctl, 32'h00, 4'h1);
        $display("test wrap done");
    endtask
    task automatic t_begin();
        wr(a_ctl, 32'hC4, 4'h1);
        put(64);
        chk({31'h0, armed}, 32'h0);
        chk({31'h0, trigger_align_bit}, 32'h1);
        rc(a_cnt, 4'hF, 32'hFF, 32'h80);
        rc(a_sts, 4'hF, 32'h80, 32'h80);
        $display("test begin_mode done");
    endtask
    task automatic t_select();
        for (int k = 0; k < 3; k++) begin
            wr(a_ctl, 32'(k), 4'h1);
            wr(a_sel, 32'(9 + k), 4'h1);
            rc(a_sel, 4'hF, 32'hF, 32'(9 + k));
        end
        chk({20'h0, sc3, sc2, sc1}, 32'hBA9);
        wr(a_ctl, 32'h03, 4'h1);
        rc(a_sel, 4'hF, 32'h7, 32'h5);
        wr(a_ctl, 32'h80, 4'h1);
        wr(a_sel, 32'hF, 4'h1);
        @(posedge clk);
        chk({28'h0, sc1}, 32'h9);
        wr(a_ctl, 32'h00, 4'h1);
        $display("test select done");
    endtask
    task automatic t_secure();
        secure <= 1'b1;
        repeat (4) @(posedge clk);
        wr(a_ctl, 32'h40, 4'h1);
        @(posedge clk);
        chk({31'h0, tsrc}, 32'h0);
        rc(a_win, 4'h3, 32'hFFFF, 32'h0);
        secure <= 1'b0;
        $display("test secure done");
    endtask

    // Counts and verdict, then the end of the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_readout();
        t_wrap();
        t_begin();
        t_select();
        t_secure();
        print_verdict();
    end
endmodule

// ==== rtl/dtb_pkg.sv ====
// Package with register map, field layout and sizes of the trace buffer readout block.
package dtb_pkg;

    // ==========================================================
    // Geometry of the trace store.
    localparam int DTB_LINE_W = 20;
    localparam int DTB_DEPTH = 64;
    localparam int DTB_PTR_W = 6;
    localparam int DTB_WIN_W = 16;

    // ==========================================================
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] DTB_IDX_CONTROL = 6'h20;
    localparam logic [5:0] DTB_IDX_STATUS = 6'h21;
    localparam logic [5:0] DTB_IDX_WINDOW = 6'h24;
    localparam logic [5:0] DTB_IDX_COUNT = 6'h26;
    localparam logic [5:0] DTB_IDX_SELECT = 6'h27;

    // ==========================================================
    // Field positions in the control register.
    localparam int DTB_CTL_ARM = 7;
    localparam int DTB_CTL_TSRC = 6;
    localparam int DTB_CTL_TRIGGER_ALIGN_BIT = 2;
    localparam int DTB_CTL_SEL_LSB = 0;

    // Field position in status and count registers, and state control width.
    localparam int DTB_FULL_BIT = 7;
    localparam int DTB_SC_W = 4;

    // ==========================================================
    // Values after reset.
    localparam logic [1:0] DTB_SEL_RESET = 2'h0;
    localparam logic [DTB_SC_W-1:0] DTB_SC_RESET = 4'h0;
    localparam logic [DTB_PTR_W-1:0] DTB_CNT_RESET = 6'h00;

    // Window select codes.
    localparam logic [1:0] DTB_SEL_STATE1 = 2'h0;
    localparam logic [1:0] DTB_SEL_STATE2 = 2'h1;
    localparam logic [1:0] DTB_SEL_STATE3 = 2'h2;
    localparam logic [1:0] DTB_SEL_MATCH = 2'h3;

    // Byte lanes that make an aligned 16-bit word access.
    localparam logic [3:0] DTB_WORD_BE = 4'h3;

endpackage

// ==== rtl/dtb_readout.sv ====
// Trace buffer readout, line counter and state control window of the debug module.
//
// Chosen here: the Avalon-MM interface to the registers.
module dtb_readout
    import dtb_pkg::*;
(
    // Clock and power-on reset.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Other system resets, synchronous, from on-chip logic.
    input wire logic sys_rst_i,
    // Avalon-MM slave.
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Security pin from outside the clock domain.
    input wire logic secure_i,
    // Trace capture and sequencer side.
    input wire logic trace_store_i,
    input wire logic [DTB_LINE_W-1:0] trace_data_i,
    input wire logic session_end_i,
    input wire logic [2:0] seq_state_i,
    input wire logic [2:0] match_flags_i,
    // Configuration seen by the sequencer and capture logic.
    output logic armed_o,
    output logic trace_source_bit_o,
    output logic trigger_align_bit_o,
    output logic tracing_en_o,
    output logic [DTB_SC_W-1:0] state_one_control_o,
    output logic [DTB_SC_W-1:0] state_two_control_o,
    output logic [DTB_SC_W-1:0] state_three_control_o,
    output logic buffer_full_flag_o,
    output logic [DTB_PTR_W-1:0] line_count_field_o
);

    // ==========================================================
    // Helpers.

    // Tells whether a byte address selects the register of a given index.
    // Register index and byte address differ by the two low address bits.
    // A misaligned byte address never hits, so it reads zero and changes nothing.
    function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
        reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    // ==========================================================
    // Declarations.
    // Synchroniser and bus registers.
    logic secure_meta_ff;
    logic secure_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    // Control, state control and counter registers.
    logic armed_ff;
    logic tsrc_ff;
    logic trigger_align_bit_ff;
    logic [1:0] sel_ff;
    logic [DTB_SC_W-1:0] sc1_ff;
    logic [DTB_SC_W-1:0] sc2_ff;
    logic [DTB_SC_W-1:0] sc3_ff;
    logic full_ff;
    logic [DTB_PTR_W-1:0] cnt_ff;
    // Lock, read pointer and trace store.
    logic locked_ff;
    logic [DTB_PTR_W-1:0] rd_line_ff;
    logic rd_half_ff;
    logic [DTB_LINE_W-1:0] mem_ff [DTB_DEPTH];
    // Combinational decode.
    logic req;
    logic take;
    logic wr_take;
    logic rd_take;
    logic word_acc;
    logic win_readable;
    logic store_ok;
    logic arm_write;
    logic ctl_write;
    logic unlock_write;
    logic begin_stop;
    logic [DTB_PTR_W-1:0] nxt_cnt;
    logic [31:0] nxt_rdata;

    // ==========================================================
    // Security synchroniser; only the second stage is used.
    // The first stage may go metastable, so nothing else reads it.
    // Security therefore takes hold two cycles after the pin moves.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            secure_meta_ff <= 1'b0;
            secure_ff <= 1'b0;
        end else begin
            secure_meta_ff <= secure_i;
            secure_ff <= secure_meta_ff;
        end
    end

    // ==========================================================
    // Bus handshake: one wait cycle, then the access is taken.
    // Waitrequest stands high in the first cycle of an access, low in the second.
    // Read data are captured at the end of the first cycle.
    assign req = read_i | write_i;
    assign take = req & ack_ff;
    // The second cycle of an access is the one that commits it.
    assign wr_take = write_i & take;
    assign rd_take = read_i & take;
    assign waitrequest_o = req & ~ack_ff;
    assign readdata_o = rdata_ff;

    // Acknowledge toggles so each access sees exactly one wait cycle.
    // It only sets while a request waits, so an idle bus leaves it low.
    // A strobe held past the commit cycle starts a new access.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Decode of access shape and trace window conditions.
    // Only an aligned 16-bit word access may read or unlock the window.
    assign word_acc = (byteenable_i == DTB_WORD_BE);
    assign win_readable = word_acc & ~locked_ff & ~secure_ff & ~armed_ff & tsrc_ff;
    // Every control field lives in lane 0.
    assign ctl_write = wr_take & reg_hit(address_i, DTB_IDX_CONTROL) & byteenable_i[0];
    assign arm_write = ctl_write & writedata_i[DTB_CTL_ARM];
    // unlock on word write
    // An unlock while armed is ignored; software must disarm first.
    assign unlock_write = wr_take & reg_hit(address_i, DTB_IDX_WINDOW) & word_acc & ~armed_ff;

    // ==========================================================
    // Read data mux, loaded in the wait cycle so it stands when waitrequest falls.
    // A refused window read yields zero.
    // Control fields read back, so software sees a begin-mode stop.
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (reg_hit(address_i, DTB_IDX_CONTROL)) begin
            nxt_rdata[DTB_CTL_ARM] = armed_ff;
            nxt_rdata[DTB_CTL_TSRC] = tsrc_ff;
            nxt_rdata[DTB_CTL_TRIGGER_ALIGN_BIT] = trigger_align_bit_ff;
            nxt_rdata[DTB_CTL_SEL_LSB+1:DTB_CTL_SEL_LSB] = sel_ff;
        end else if (reg_hit(address_i, DTB_IDX_STATUS)) begin
            nxt_rdata[DTB_FULL_BIT] = full_ff;
            nxt_rdata[2:0] = seq_state_i;
        end else if (reg_hit(address_i, DTB_IDX_WINDOW)) begin
            if (win_readable) begin
                if (rd_half_ff) begin
                    // The top four bits of a line come back in the low nibble.
                    nxt_rdata[DTB_LINE_W-DTB_WIN_W-1:0] = mem_ff[rd_line_ff][DTB_LINE_W-1:DTB_WIN_W];
                end else begin
                    nxt_rdata[DTB_WIN_W-1:0] = mem_ff[rd_line_ff][DTB_WIN_W-1:0];
                end
            end
        end else if (reg_hit(address_i, DTB_IDX_COUNT)) begin
            nxt_rdata[DTB_FULL_BIT] = full_ff;
            nxt_rdata[DTB_PTR_W-1:0] = cnt_ff;
        end else if (reg_hit(address_i, DTB_IDX_SELECT)) begin
            // select window mux
            // Code 3 shows the match flags, which are read only.
            unique case (sel_ff)
                DTB_SEL_STATE1: nxt_rdata[DTB_SC_W-1:0] = sc1_ff;
                DTB_SEL_STATE2: nxt_rdata[DTB_SC_W-1:0] = sc2_ff;
                DTB_SEL_STATE3: nxt_rdata[DTB_SC_W-1:0] = sc3_ff;
                DTB_SEL_MATCH: nxt_rdata[2:0] = match_flags_i;
            endcase
        end
    end

    // Read data register; unmapped addresses read as zero.
    // It loads only in the wait cycle, so it holds while the master takes it.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (read_i & ~ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // Arming and session control; other resets disarm the module.
    // A begin-mode session ends on the store that fills the last line.
    assign begin_stop = store_ok & trigger_align_bit_ff & (cnt_ff == DTB_PTR_W'(DTB_DEPTH - 1));

    // Arm bit is set by software and cleared by software, session end or a begin-mode wrap.
    // A software write wins over a session end in the same cycle.
    // Other resets disarm but leave count, flag, lock and pointer alone.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_ff <= 1'b0;
        end else if (sys_rst_i) begin
            armed_ff <= 1'b0;
        end else if (ctl_write) begin
            armed_ff <= writedata_i[DTB_CTL_ARM];
        end else if (session_end_i | begin_stop) begin
            armed_ff <= 1'b0;
        end
    end

    // Trace source, alignment and window select fields of the control register.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tsrc_ff <= 1'b0;
            trigger_align_bit_ff <= 1'b0;
            sel_ff <= DTB_SEL_RESET;
        end else if (sys_rst_i) begin
            tsrc_ff <= 1'b0;
            trigger_align_bit_ff <= 1'b0;
            sel_ff <= DTB_SEL_RESET;
        end else begin
            if (secure_ff) begin
                tsrc_ff <= 1'b0;
            end else if (ctl_write & ~armed_ff) begin
                tsrc_ff <= writedata_i[DTB_CTL_TSRC];
            end
            // The select field may move at any time.
            if (ctl_write) begin
                sel_ff <= writedata_i[DTB_CTL_SEL_LSB+1:DTB_CTL_SEL_LSB];
            end
            // alignment select
            // Alignment is frozen while armed, secured or not.
            if (ctl_write & ~armed_ff) begin
                trigger_align_bit_ff <= writedata_i[DTB_CTL_TRIGGER_ALIGN_BIT];
            end
        end
    end

    // ==========================================================
    // State control registers behind the shared select window.
    // Writes land where the select field points and are refused while armed.
    // Code 3 writes are dropped: the match flags come from the sequencer.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sc1_ff <= DTB_SC_RESET;
            sc2_ff <= DTB_SC_RESET;
            sc3_ff <= DTB_SC_RESET;
        end else if (sys_rst_i) begin
            sc1_ff <= DTB_SC_RESET;
            sc2_ff <= DTB_SC_RESET;
            sc3_ff <= DTB_SC_RESET;
        end else if (wr_take & reg_hit(address_i, DTB_IDX_SELECT) & byteenable_i[0] & ~armed_ff) begin
            unique case (sel_ff)
                DTB_SEL_STATE1: sc1_ff <= writedata_i[DTB_SC_W-1:0];
                DTB_SEL_STATE2: sc2_ff <= writedata_i[DTB_SC_W-1:0];
                DTB_SEL_STATE3: sc3_ff <= writedata_i[DTB_SC_W-1:0];
                DTB_SEL_MATCH: ;
            endcase
        end
    end

    // Configuration outputs come straight from their registers.
    // controls to sequencer
    assign state_one_control_o = sc1_ff;
    assign state_two_control_o = sc2_ff;
    assign state_three_control_o = sc3_ff;
    assign armed_o = armed_ff;
    assign trace_source_bit_o = tsrc_ff;
    assign trigger_align_bit_o = trigger_align_bit_ff;
    // tracing inhibited when secured
    // Tracing stops as soon as security is seen, whatever the source bit holds.
    assign tracing_en_o = armed_ff & tsrc_ff & ~secure_ff;

    // ==========================================================
    // Line counter and full flag; only power-on reset and arming clear them.
    assign store_ok = trace_store_i & armed_ff & tsrc_ff & ~secure_ff & ~arm_write;
    // Six bits wrap on their own after the last line.
    assign nxt_cnt = cnt_ff + 6'h01;

    // Counter advances on each stored line; reads never touch it.
    // A store in the cycle of an arming write is dropped.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= DTB_CNT_RESET;
            full_ff <= 1'b0;
        end else if (arm_write) begin
            cnt_ff <= DTB_CNT_RESET;
            full_ff <= 1'b0;
        end else if (store_ok) begin
            // wrap keeps counting in end mode
            cnt_ff <= nxt_cnt;
            if (nxt_cnt == DTB_CNT_RESET) begin
                // The wrap to zero marks the sixty-fourth line since arming.
                // sixty-four lines stored
                full_ff <= 1'b1;
            end
        end
    end

    // Count and full flag go out as stored.
    // Both survive system resets until the next arming.
    assign buffer_full_flag_o = full_ff;
    assign line_count_field_o = cnt_ff;

    // ==========================================================
    // Trace store: no reset, so contents survive every reset but power-on leaves them undefined.
    // no reset on storage
    // ring overwrites oldest
    // The write index is the count, so after a wrap the newest replaces the oldest.
    // Lines read before their first store are undefined.
    always_ff @(posedge ref_clk_i) begin
        if (store_ok) begin
            mem_ff[cnt_ff] <= trace_data_i;
        end
    end

    // ==========================================================
    // Lock and read pointer.
    // Unlocking restarts readout at the oldest line: zero, or the count once full.
    // The low half of a line is read first, then the top bits.
    // Arming locks again; the pointer waits for the next unlock.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            locked_ff <= 1'b1;
            rd_line_ff <= DTB_CNT_RESET;
            rd_half_ff <= 1'b0;
        end else if (arm_write) begin
            locked_ff <= 1'b1;
        end else if (unlock_write) begin
            locked_ff <= 1'b0;
            rd_line_ff <= full_ff ? cnt_ff : DTB_CNT_RESET;
            rd_half_ff <= 1'b0;
        end else if (rd_take & reg_hit(address_i, DTB_IDX_WINDOW) & win_readable) begin
            // advance on valid read
            // The half select flips on each read; the line moves after the top half.
            rd_half_ff <= ~rd_half_ff;
            if (rd_half_ff) begin
                rd_line_ff <= rd_line_ff + 6'h01;
            end
        end
    end

endmodule
